// >>> comparator_control_defs.svh
// Purpose: offsets, field positions, reset values for the comparator control block
// Assumes: byte registers on a plain strobe port
// Notes: a few control inputs stand as plain ports
// How it works
// (RL1) interrupt enable bit turns source on/off
// (RL2) irq high while enabled and flag set
// (RL3) idle sleep behaves as active
// (RL4) standby disables unless run_in_standby set
// (RL5) power down disables comparator and pad
// (RL6) run_in_standby bit 7; flags frozen clockless
// (RL7) output_pad_enable bit 6 drives pin
// (RL8) edge_select 5:4 chooses interrupt edge
// (RL9) bit 3 drives low power select
// (RL10) hysteresis_select 2:1 passed to comparator
// (RL11) bit 0 enables comparator
// (RL12) invert bit 7 flips output everywhere
// (RL13) mux bits 4:3 choose positive pin
// (RL14) mux bits 1:0 choose negative/divider
// (RL15) divider register resets to 0xff
// (RL16) chosen edge sets interrupt flag
// (RL17) interrupt control bit 0 enables interrupt
// (RL18) status bit 4 shows synced state
// (RL19) write one to status bit 0 clears
// (RL20) synchronise comparator output before edge detect
`ifndef COMPARATOR_CONTROL_DEFS_SVH
`define COMPARATOR_CONTROL_DEFS_SVH
`define OFS_CONTROL_A 3'h0
`define OFS_INPUT_MUX_CONTROL 3'h2
`define OFS_REFERENCE_DIVIDER_VALUE 3'h4
`define OFS_INTERRUPT_CONTROL 3'h6
`define OFS_COMPARATOR_STATUS 3'h7
`define BIT_ENABLE 0
`define BIT_LOW_POWER 3
`define BIT_OUTPUT_PAD_ENABLE 6
`define BIT_RUN_IN_STANDBY 7
`define BIT_INVERT 7
`define BIT_STATE 4
`define EDGE_MSB 5
`define EDGE_LSB 4
`define HYST_MSB 2
`define HYST_LSB 1
`define POS_MSB 4
`define POS_LSB 3
`define NEG_MSB 1
`define NEG_LSB 0
`define MUX_WRITE_MASK 8'h9b
`define BIT_COMPARE_INTERRUPT 0
`define RST_CONTROL_A 8'h00
`define RST_INPUT_MUX_CONTROL 8'h00
`define RST_REFERENCE_DIVIDER_VALUE 8'hff
`define RST_INTERRUPT_CONTROL 8'h00
`endif

// >>> comparator_control_pkg.sv
// Purpose: types for the comparator control block
// Assumes: nothing
// Notes: edge select encoding
package comparator_control_pkg;
    typedef enum logic [1:0] {any_edge = 2'h0, edge_reserved = 2'h1, falling_edge = 2'h2, rising_edge = 2'h3} edge_t;
    typedef enum logic [1:0] {sleep_active = 2'h0, sleep_idle = 2'h1, sleep_standby = 2'h2, sleep_power_down = 2'h3}
        sleep_t;
endpackage

// >>> comparator_control.sv
// Purpose: control and status logic around one analog comparator
// Assumes: compare_raw is asynchronous; sleep_mode comes from the same clock
// Notes: reads return data one cycle after the read strobe
//
// The plain strobed port was decided locally.
`timescale 1ns/10ps
`include "comparator_control_defs.svh"
module comparator_control
    import comparator_control_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic [2:0] address,
    input wire logic [7:0] write_data,
    input wire logic write_strobe,
    input wire logic read_strobe,
    output logic [7:0] read_data,
    input wire logic [1:0] sleep_mode,
    input wire logic compare_raw,
    output logic comparator_enable,
    output logic low_power_select,
    output logic [1:0] hysteresis_select,
    output logic [1:0] positive_input_select,
    output logic [1:0] negative_input_select,
    output logic [7:0] divider_reference_level,
    output logic compare_out,
    output logic pad_out,
    output logic pad_out_enable,
    output logic irq
);
    logic enable_bit;
    logic low_power_bit;
    logic [1:0] hysteresis_field;
    logic [1:0] edge_field;
    logic pad_enable_bit;
    logic standby_bit;
    logic [7:0] input_mux_control;
    logic [7:0] reference_divider_value;
    logic interrupt_enable;
    logic flag;
    logic sync_a;
    logic sync_b;
    logic state;
    logic [7:0] next_read_data;

    // reset image of control a, sliced per field
    localparam logic [7:0] control_a_reset = `RST_CONTROL_A;

    // address match, shared by all write strobes
    function automatic logic offset_hit(input logic [2:0] addr, input logic [2:0] offset);
        return addr == offset;
    endfunction

    // edge decode; reserved code never fires, so a stray setting cannot raise irq
    function automatic logic edge_hit(input edge_t mode, input logic up, input logic down);
        logic result;
        result = 1'b0;
        case (mode)
            any_edge: result = up | down;
            falling_edge: result = down;
            rising_edge: result = up;
            default: result = 1'b0;
        endcase
        return result;
    endfunction

    // control a as software sees it
    wire [7:0] control_a = {standby_bit, pad_enable_bit, edge_field, low_power_bit, hysteresis_field, enable_bit};
    wire edge_t edge_select = edge_t'(edge_field);

    // input mux control fields
    wire invert = input_mux_control[`BIT_INVERT];

    // sleep gating
    wire sleep_t mode = sleep_t'(sleep_mode);
    wire in_standby = (mode == sleep_standby);
    wire in_power_down = (mode == sleep_power_down);
    // idle counts as active, so nothing below looks at it
    wire run_allowed = ~in_power_down & (~in_standby | standby_bit); // RL3 RL4 RL5 RL6
    // clock treated as stopped in standby, so flags and state freeze there
    wire flags_live = ~in_standby & ~in_power_down; // RL6

    // analog-side controls from the register flops; comparator_enable is also gated by run_allowed
    assign comparator_enable = enable_bit & run_allowed; // RL11 RL4 RL5
    assign low_power_select = low_power_bit; // RL9
    assign hysteresis_select = hysteresis_field; // RL10
    assign positive_input_select = input_mux_control[`POS_MSB:`POS_LSB]; // RL13
    assign negative_input_select = input_mux_control[`NEG_MSB:`NEG_LSB]; // RL14
    assign divider_reference_level = reference_divider_value; // RL15

    // inversion after the synchroniser feeds pad, events and status alike;
    // costs two cycles of lag on the pad but keeps the raw pin out of logic
    assign compare_out = (sync_b ^ invert) & comparator_enable; // RL12 RL20
    assign pad_out = compare_out; // RL7
    assign pad_out_enable = pad_enable_bit & ~in_power_down & run_allowed; // RL7 RL5

    // edge detect against the last sampled state
    wire rose = compare_out & ~state;
    wire fell = ~compare_out & state;
    wire hit = edge_hit(edge_select, rose, fell); // RL8
    wire event_seen = hit & flags_live & comparator_enable; // RL16

    // per-register write strobes
    wire wr_control_a = write_strobe & offset_hit(address, `OFS_CONTROL_A);
    wire wr_input_mux = write_strobe & offset_hit(address, `OFS_INPUT_MUX_CONTROL);
    wire wr_divider = write_strobe & offset_hit(address, `OFS_REFERENCE_DIVIDER_VALUE);
    wire wr_interrupt = write_strobe & offset_hit(address, `OFS_INTERRUPT_CONTROL);
    wire wr_status = write_strobe & offset_hit(address, `OFS_COMPARATOR_STATUS);
    // writing zero to the flag bit leaves it alone
    wire clear_flag = wr_status & write_data[`BIT_COMPARE_INTERRUPT]; // RL19

    // read-side words
    wire [7:0] status_word = {3'h0, state, 3'h0, flag}; // RL18
    wire [7:0] interrupt_word = {7'h00, interrupt_enable};

    // level request, held until the flag is cleared or the source masked
    assign irq = interrupt_enable & flag; // RL2 RL1

    // synchroniser first stage: only the second stage reads it
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            sync_a <= 1'b0;
        end
        else
        begin
            sync_a <= compare_raw; // RL20
        end
    end

    // synchroniser second stage
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            sync_b <= 1'b0;
        end
        else
        begin
            sync_b <= sync_a; // RL20
        end
    end

    // third flop: status state, three cycles behind the pin
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            state <= 1'b0;
        end
        else if (flags_live)
        begin
            state <= compare_out; // RL18
        end
    end

    // interrupt flag: set beats clear in the same cycle
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            flag <= 1'b0;
        end
        else if (event_seen)
        begin
            flag <= 1'b1; // RL16
        end
        else if (clear_flag)
        begin
            flag <= 1'b0; // RL19
        end
    end

    // comparator enable bit
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            enable_bit <= control_a_reset[`BIT_ENABLE];
        end
        else if (wr_control_a)
        begin
            enable_bit <= write_data[`BIT_ENABLE]; // RL11
        end
    end

    // low power select; trades speed for current
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            low_power_bit <= control_a_reset[`BIT_LOW_POWER];
        end
        else if (wr_control_a)
        begin
            low_power_bit <= write_data[`BIT_LOW_POWER]; // RL9
        end
    end

    // hysteresis field, passed on unchanged
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            hysteresis_field <= control_a_reset[`HYST_MSB:`HYST_LSB];
        end
        else if (wr_control_a)
        begin
            hysteresis_field <= write_data[`HYST_MSB:`HYST_LSB]; // RL10
        end
    end

    // edge select field
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            edge_field <= control_a_reset[`EDGE_MSB:`EDGE_LSB];
        end
        else if (wr_control_a)
        begin
            edge_field <= write_data[`EDGE_MSB:`EDGE_LSB]; // RL8
        end
    end

    // output pad enable bit
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            pad_enable_bit <= control_a_reset[`BIT_OUTPUT_PAD_ENABLE];
        end
        else if (wr_control_a)
        begin
            pad_enable_bit <= write_data[`BIT_OUTPUT_PAD_ENABLE]; // RL7
        end
    end

    // run in standby bit
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            standby_bit <= control_a_reset[`BIT_RUN_IN_STANDBY];
        end
        else if (wr_control_a)
        begin
            standby_bit <= write_data[`BIT_RUN_IN_STANDBY]; // RL6
        end
    end

    // input mux control; unused bits kept at zero so they read back zero
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            input_mux_control <= `RST_INPUT_MUX_CONTROL;
        end
        else if (wr_input_mux)
        begin
            input_mux_control <= write_data & `MUX_WRITE_MASK; // RL12 RL13 RL14
        end
    end

    // divider code
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            reference_divider_value <= `RST_REFERENCE_DIVIDER_VALUE; // RL15
        end
        else if (wr_divider)
        begin
            reference_divider_value <= write_data;
        end
    end

    // interrupt source enable
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            interrupt_enable <= 1'b0;
        end
        else if (wr_interrupt)
        begin
            interrupt_enable <= write_data[`BIT_COMPARE_INTERRUPT]; // RL17 RL1
        end
    end

    // read mux; unmapped addresses read zero
    always_comb
    begin
        case (address)
            `OFS_CONTROL_A: next_read_data = control_a;
            `OFS_INPUT_MUX_CONTROL: next_read_data = input_mux_control;
            `OFS_REFERENCE_DIVIDER_VALUE: next_read_data = reference_divider_value;
            `OFS_INTERRUPT_CONTROL: next_read_data = interrupt_word;
            `OFS_COMPARATOR_STATUS: next_read_data = status_word; // RL18
            default: next_read_data = 8'h00;
        endcase
    end

    // read data stands one cycle only, zero otherwise
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            read_data <= 8'h00;
        end
        else if (read_strobe)
        begin
            read_data <= next_read_data;
        end
        else
        begin
            read_data <= 8'h00;
        end
    end
endmodule

// >>> comparator_control_props.sv
// Purpose: checker for comparator control ports
// Assumes: one clock, sync reset
// Notes: bound into every instance
`timescale 1ns/10ps
module comparator_control_props (
    input wire logic clk,
    input wire logic reset,
    input wire logic [2:0] address,
    input wire logic [7:0] write_data,
    input wire logic write_strobe,
    input wire logic [1:0] sleep_mode,
    input wire logic comparator_enable,
    input wire logic low_power_select,
    input wire logic [1:0] hysteresis_select,
    input wire logic [1:0] positive_input_select,
    input wire logic [1:0] negative_input_select,
    input wire logic [7:0] divider_reference_level,
    input wire logic compare_out,
    input wire logic pad_out,
    input wire logic pad_out_enable,
    input wire logic irq
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (reset);
    a_pad_enable: assert property (write_strobe && address == 3'h0 && sleep_mode == 2'h0 |=>
        sleep_mode != 2'h0 || pad_out_enable == $past(write_data[6])) else $error("pad enable wrong");
    a_power_down: assert property (sleep_mode == 2'h3 |-> !comparator_enable && !pad_out_enable)
        else $error("power down left on");
    a_enable_write: assert property (write_strobe && address == 3'h0 && sleep_mode == 2'h0 |=>
        sleep_mode != 2'h0 || comparator_enable == $past(write_data[0])) else $error("enable wrong");
    a_analog_fields: assert property (write_strobe && address == 3'h0 |=>
        {low_power_select, hysteresis_select} == $past(write_data[3:1])) else $error("analog fields");
    a_mux_fields: assert property (write_strobe && address == 3'h2 |=>
        {positive_input_select, negative_input_select} == {$past(write_data[4:3]), $past(write_data[1:0])})
        else $error("mux fields");
    a_divider_write: assert property (write_strobe && address == 3'h4 |=>
        divider_reference_level == $past(write_data)) else $error("divider");
    a_irq_hold: assert property (irq && !write_strobe |=> irq)
        else $error("irq dropped");
    a_irq_off: assert property (write_strobe && address == 3'h6 && !write_data[0] |=> !irq)
        else $error("irq not masked");
endmodule
bind comparator_control comparator_control_props u_comparator_control_props (.clk, .reset, .address,
    .write_data, .write_strobe, .sleep_mode, .comparator_enable, .low_power_select, .hysteresis_select,
    .positive_input_select, .negative_input_select, .divider_reference_level, .compare_out, .pad_out,
    .pad_out_enable, .irq);

// >>> comparator_core_model.sv
// Purpose: comparator core stand-in
// Assumes: level set by the bench
// Notes: output is junk while disabled
`timescale 1ns/10ps
module comparator_core_model (
    input wire logic enable,
    input wire logic level,
    output logic out
);
    // a disabled core has no valid result, so show the inverse
    assign #1 out = enable ? level : ~level;
endmodule

// >>> testbench.sv
// Purpose: register and edge tests
// Assumes: strobe port, 250 MHz clock
// Notes: waits of six cycles cover the synchroniser
`timescale 1ns/10ps
module testbench;
    logic clk = 0, reset = 1, write_strobe = 0, read_strobe = 0, level = 0;
    logic [2:0] address = 3'h0;
    logic [7:0] write_data = 8'h00;
    logic [1:0] sleep_mode = 2'h0;
    logic [7:0] read_data;
    logic comparator_enable, compare_raw, compare_out, pad_out_enable, irq;
    int bad_count = 0, n_checks = 0, cycles = 0;
    comparator_control u_comparator_control (.clk, .reset, .address, .write_data, .write_strobe,
        .read_strobe, .read_data, .sleep_mode, .compare_raw, .comparator_enable, .low_power_select(),
        .hysteresis_select(), .positive_input_select(), .negative_input_select(),
        .divider_reference_level(), .compare_out, .pad_out(), .pad_out_enable, .irq);
    comparator_core_model u_comparator_core_model (.enable(comparator_enable), .level, .out(compare_raw));
    initial
        forever #2 clk = ~clk;
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        address <= a;
        write_data <= d;
        write_strobe <= 1'b1;
        @(posedge clk);
        write_strobe <= 1'b0;
    endtask
    task automatic rd(input logic [2:0] a, input logic [7:0] exp);
        @(posedge clk);
        address <= a;
        read_strobe <= 1'b1;
        @(posedge clk);
        read_strobe <= 1'b0;
        #1 check(read_data, exp);
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // hang guard, far above the under two hundred cycles needed
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            bad_count++;
            finish_test();
        end
    end
    initial
    begin
        repeat (12) @(posedge clk);
        reset <= 1'b0;
        rd(3'h0, 8'h00);
        rd(3'h2, 8'h00);
        rd(3'h4, 8'hff);
        rd(3'h6, 8'h00);
        rd(3'h1, 8'h00);
        wr(3'h4, 8'h5a);
        rd(3'h4, 8'h5a);
        wr(3'h2, 8'hff);
        rd(3'h2, 8'h9b);
        wr(3'h2, 8'h80);
        wr(3'h0, 8'h41);
        repeat (6) @(posedge clk);
        wr(3'h7, 8'h01);
        rd(3'h7, 8'h10);
        $display("test registers done");
        // standby halts without run_in_standby, idle runs as active
        sleep_mode <= 2'h2;
        @(posedge clk);
        #1 check({7'h00, comparator_enable}, 8'h00);
        wr(3'h0, 8'hc1);
        #1 check({7'h00, comparator_enable}, 8'h01);
        sleep_mode <= 2'h3;
        @(posedge clk);
        #1 check({6'h00, comparator_enable, pad_out_enable}, 8'h00);
        sleep_mode <= 2'h1;
        @(posedge clk);
        #1 check({6'h00, comparator_enable, pad_out_enable}, 8'h03);
        sleep_mode <= 2'h0;
        $display("test sleep done");
        wr(3'h2, 8'h00);
        wr(3'h6, 8'h01);
        for (int m = 0; m < 4; m++)
        begin
            wr(3'h0, {2'b00, m[1:0], 4'h1});
            repeat (6) @(posedge clk);
            wr(3'h7, 8'h01);
            level <= 1'b1;
            repeat (6) @(posedge clk);
            rd(3'h7, {7'h08, m == 0 || m == 3});
            check({7'h00, irq}, {7'h00, m == 0 || m == 3});
            wr(3'h7, 8'h01);
            level <= 1'b0;
            repeat (6) @(posedge clk);
            rd(3'h7, {7'h00, m == 0 || m == 2});
        end
        level <= 1'b1;
        repeat (6) @(posedge clk);
        wr(3'h6, 8'h00);
        #1 check({7'h00, irq}, 8'h00);
        $display("test edges done");
        finish_test();
    end
endmodule
